// [core/oag_top.sv]
// Operand address and instruction length generator
`timescale 1ns/1ps
// Overview of operation
// [RQ1] Inherent: one byte, no operand address
// [RQ2] Immediate: two bytes, operand is data
// [RQ3] Direct: two bytes, high byte zero
// [RQ4] Bit branch: three bytes, direct then offset
// [RQ5] Extended: three bytes, high then low
// [RQ6] Indexed no offset: one byte, page zero
// [RQ7] Indexed 8-bit: two bytes, unsigned sum
// [RQ8] Indexed 16-bit: three bytes, offset high first
// [RQ9] Relative taken: next pc plus signed offset
// [RQ10] Relative displacement only for branches
// [RQ11] 16-bit indexed sum wraps at top
module oag_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Decoded instruction
  input wire logic instr_valid,
  input wire oag_pkg::oag_mode_t mode,
  input wire logic branch_cond,
  input wire logic [15:0] instr_pc,
  input wire logic [7:0] index_reg,
  input wire logic [7:0] op_byte1,
  input wire logic [7:0] op_byte2,
  // Results
  output logic res_valid,
  output logic [1:0] instr_len,
  output logic addr_valid,
  output logic [15:0] operand_addr,
  output logic imm_valid,
  output logic [7:0] imm_data,
  output logic [15:0] pc_next,
  output logic branch_taken
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic res_valid;
    logic [1:0] len;
    logic addr_valid;
    logic [15:0] addr;
    logic imm_valid;
    logic [7:0] imm;
    logic [15:0] pc;
    logic taken;
  } oag_state_t;

  oag_state_t st_r;
  oag_state_t st_nxt;
  logic [1:0] len_c;
  logic [15:0] seq_pc;

  oag_if ops ();

  // ----------------------------------------------------------------
  // Length decode
  // ----------------------------------------------------------------
  always_comb begin
    case (mode)
      oag_pkg::OAG_INH: len_c = oag_pkg::OAG_LEN_ONE; // [RQ1]
      oag_pkg::OAG_IX0: len_c = oag_pkg::OAG_LEN_ONE; // [RQ6]
      oag_pkg::OAG_IMM: len_c = oag_pkg::OAG_LEN_TWO; // [RQ2]
      oag_pkg::OAG_DIR: len_c = oag_pkg::OAG_LEN_TWO; // [RQ3]
      oag_pkg::OAG_IX1: len_c = oag_pkg::OAG_LEN_TWO; // [RQ7]
      oag_pkg::OAG_REL: len_c = oag_pkg::OAG_LEN_TWO; // [RQ9]
      oag_pkg::OAG_EXT: len_c = oag_pkg::OAG_LEN_THREE; // [RQ5]
      oag_pkg::OAG_IX2: len_c = oag_pkg::OAG_LEN_THREE; // [RQ8]
      oag_pkg::OAG_BTB: len_c = oag_pkg::OAG_LEN_THREE; // [RQ4]
      default: len_c = oag_pkg::OAG_LEN_ONE;
    endcase
  end

  assign seq_pc = instr_pc + {14'h0000, len_c};

  // Relative branch offset sits in byte1, bit branch offset in byte2
  assign ops.index_val = index_reg;
  assign ops.byte1 = op_byte1;
  assign ops.byte2 = (mode == oag_pkg::OAG_REL) ? op_byte1 : op_byte2;
  assign ops.pc_next_seq = seq_pc;

  oag_adder u_adder (
    .a(ops.calc)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.res_valid = instr_valid;
    if (instr_valid) begin
      st_nxt.len = len_c;
      st_nxt.addr_valid = 1'h0;
      st_nxt.addr = 16'h0000;
      st_nxt.imm_valid = 1'h0;
      st_nxt.imm = 8'h00;
      st_nxt.pc = seq_pc;
      st_nxt.taken = 1'h0;
      case (mode)
        oag_pkg::OAG_INH: begin
          st_nxt.addr_valid = 1'h0; // [RQ1]
        end
        oag_pkg::OAG_IMM: begin
          // Data passed through, never driven onto the address path
          st_nxt.imm_valid = 1'h1; // [RQ2]
          st_nxt.imm = op_byte1; // [RQ2]
        end
        oag_pkg::OAG_DIR: begin
          st_nxt.addr_valid = 1'h1;
          st_nxt.addr = {oag_pkg::OAG_PAGE0_HI, op_byte1}; // [RQ3]
        end
        oag_pkg::OAG_EXT: begin
          st_nxt.addr_valid = 1'h1;
          st_nxt.addr = {op_byte1, op_byte2}; // [RQ5]
        end
        oag_pkg::OAG_IX0: begin
          st_nxt.addr_valid = 1'h1;
          st_nxt.addr = {oag_pkg::OAG_PAGE0_HI, index_reg}; // [RQ6]
        end
        oag_pkg::OAG_IX1: begin
          st_nxt.addr_valid = 1'h1;
          st_nxt.addr = ops.ix1_sum; // [RQ7]
        end
        oag_pkg::OAG_IX2: begin
          st_nxt.addr_valid = 1'h1;
          st_nxt.addr = ops.ix2_sum; // [RQ8]
        end
        oag_pkg::OAG_REL: begin
          // No operand address: displacement steers the pc only
          st_nxt.taken = branch_cond; // [RQ10]
          st_nxt.pc = branch_cond ? ops.rel_tgt : seq_pc; // [RQ9]
        end
        oag_pkg::OAG_BTB: begin
          st_nxt.addr_valid = 1'h1;
          st_nxt.addr = {oag_pkg::OAG_PAGE0_HI, op_byte1}; // [RQ4]
          st_nxt.taken = branch_cond; // [RQ4]
          st_nxt.pc = branch_cond ? ops.rel_tgt : seq_pc; // [RQ9]
        end
        default: begin
          st_nxt.addr_valid = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.pc <= oag_pkg::OAG_PC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign res_valid = st_r.res_valid;
  assign instr_len = st_r.len;
  assign addr_valid = st_r.addr_valid;
  assign operand_addr = st_r.addr;
  assign imm_valid = st_r.imm_valid;
  assign imm_data = st_r.imm;
  assign pc_next = st_r.pc;
  assign branch_taken = st_r.taken;
endmodule : oag_top

// [include/oag_pkg.sv]
// Package: addressing modes, instruction lengths and field positions
package oag_pkg;
  // ----------------------------------------------------------------
  // Addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OAG_INH,
    OAG_IMM,
    OAG_DIR,
    OAG_EXT,
    OAG_IX0,
    OAG_IX1,
    OAG_IX2,
    OAG_REL,
    OAG_BTB
  } oag_mode_t;

  // ----------------------------------------------------------------
  // Lengths and widths
  // ----------------------------------------------------------------
  localparam logic [1:0] OAG_LEN_ONE = 2'h1;
  localparam logic [1:0] OAG_LEN_TWO = 2'h2;
  localparam logic [1:0] OAG_LEN_THREE = 2'h3;
  localparam int OAG_ADDR_W = 16;
  localparam int OAG_DATA_W = 8;
  localparam logic [7:0] OAG_PAGE0_HI = 8'h00;
  localparam logic [15:0] OAG_PC_RST = 16'h0000;
  localparam int OAG_SIGN_BIT = 7;
endpackage : oag_pkg

// [include/oag_if.sv]
// Interface: operand bytes from the fetch side into the address adder
`timescale 1ns/1ps
interface oag_if;
  logic [7:0] index_val;
  logic [7:0] byte1;
  logic [7:0] byte2;
  logic [15:0] pc_next_seq;
  logic [15:0] ix1_sum;
  logic [15:0] ix2_sum;
  logic [15:0] rel_tgt;
  modport src (output index_val, byte1, byte2, pc_next_seq,
               input ix1_sum, ix2_sum, rel_tgt);
  modport calc (input index_val, byte1, byte2, pc_next_seq,
                output ix1_sum, ix2_sum, rel_tgt);
endinterface : oag_if

// [core/oag_adder.sv]
// Combinational adders for indexed and relative effective addresses
`timescale 1ns/1ps
module oag_adder (
  oag_if.calc a
);
  logic [16:0] ix2_full;

  // Both operands unsigned, zero extended
  assign a.ix1_sum = {8'h00, a.index_val} + {8'h00, a.byte1}; // [RQ7]
  assign ix2_full = {9'h000, a.index_val} + {1'h0, a.byte1, a.byte2}; // [RQ8]
  // Carry out of bit 15 dropped: wraps over the top of memory
  assign a.ix2_sum = ix2_full[15:0]; // [RQ11]
  // Displacement measured from the byte after the branch
  assign a.rel_tgt = a.pc_next_seq + {{8{a.byte2[oag_pkg::OAG_SIGN_BIT]}}, a.byte2}; // [RQ9]
endmodule : oag_adder

// [tb/oag_mem_model.sv]
// Program memory model feeding the bytes that follow an opcode
`timescale 1ns/1ps
module oag_mem_model (
  // Fetch address and bytes
  input wire logic [15:0] pc,
  output logic [7:0] b1,
  output logic [7:0] b2
);
  // Pattern gives bytes ff and fe at pc 0x0100, the awkward edges of every adder
  assign b1 = ~pc[7:0];
  assign b2 = ~pc[15:8];
endmodule : oag_mem_model

// [tb/oag_properties.sv]
// Checker: operand address generator properties
`timescale 1ns/1ps
module oag_checker (
  // Clock, reset, request
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire oag_pkg::oag_mode_t mode,
  input wire logic branch_cond,
  input wire logic [15:0] instr_pc,
  input wire logic [7:0] index_reg,
  input wire logic [7:0] op_byte1,
  input wire logic [7:0] op_byte2,
  // Results
  input wire logic [1:0] instr_len,
  input wire logic addr_valid,
  input wire logic [15:0] operand_addr,
  input wire logic imm_valid,
  input wire logic [7:0] imm_data,
  input wire logic [15:0] pc_next,
  input wire logic branch_taken
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  inh_len_a: assert property (instr_valid && mode == oag_pkg::OAG_INH |=>
    instr_len == 2'h1 && !addr_valid && !imm_valid) else $error("bad inherent");
  imm_data_a: assert property (instr_valid && mode == oag_pkg::OAG_IMM |=>
    imm_valid && !addr_valid && imm_data == $past(op_byte1)) else $error("bad immediate");
  dir_page_a: assert property (instr_valid && mode == oag_pkg::OAG_DIR |=>
    operand_addr == {8'h00, $past(op_byte1)}) else $error("bad direct");
  ext_addr_a: assert property (instr_valid && mode == oag_pkg::OAG_EXT |=>
    operand_addr == {$past(op_byte1), $past(op_byte2)}) else $error("bad extended");
  ix0_page_a: assert property (instr_valid && mode == oag_pkg::OAG_IX0 |=>
    instr_len == 2'h1 && addr_valid && operand_addr == {8'h00, $past(index_reg)})
    else $error("bad ix0");
  ix1_sum_a: assert property (instr_valid && mode == oag_pkg::OAG_IX1 |=>
    operand_addr == $past(index_reg) + $past(op_byte1)) else $error("bad ix1");
  ix2_wrap_a: assert property (instr_valid && mode == oag_pkg::OAG_IX2 |=>
    operand_addr == {$past(op_byte1), $past(op_byte2)} + $past(index_reg))
    else $error("bad ix2");
  rel_target_a: assert property (instr_valid && mode == oag_pkg::OAG_REL |=>
    pc_next == $past(instr_pc) + 16'h2 + ($past(branch_cond) ?
    {{8{$past(op_byte1[7])}}, $past(op_byte1)} : 16'h0)) else $error("bad relative");
  btb_target_a: assert property (instr_valid && mode == oag_pkg::OAG_BTB |=>
    instr_len == 2'h3 && operand_addr == {8'h00, $past(op_byte1)} &&
    branch_taken == $past(branch_cond) && pc_next == $past(instr_pc) + 16'h3 +
    ($past(branch_cond) ? {{8{$past(op_byte2[7])}}, $past(op_byte2)} : 16'h0))
    else $error("bad bit branch");
  rel_only_a: assert property (instr_valid &&
    mode inside {[oag_pkg::OAG_INH:oag_pkg::OAG_IX2]} |=> !branch_taken)
    else $error("bad taken");
endmodule : oag_checker
bind oag_top oag_checker u_oag_checker (
  .clk(clk),
  .sys_rst(sys_rst),
  .instr_valid(instr_valid),
  .mode(mode),
  .branch_cond(branch_cond),
  .instr_pc(instr_pc),
  .index_reg(index_reg),
  .op_byte1(op_byte1),
  .op_byte2(op_byte2),
  .instr_len(instr_len),
  .addr_valid(addr_valid),
  .operand_addr(operand_addr),
  .imm_valid(imm_valid),
  .imm_data(imm_data),
  .pc_next(pc_next),
  .branch_taken(branch_taken)
);

// [tb/oag_top_tb.sv]
// Testbench: operand address generator
`timescale 1ns/1ps
module oag_top_tb;
  logic clk = 1'h0, sys_rst = 1'h1, instr_valid = 1'h0, branch_cond = 1'h0;
  oag_pkg::oag_mode_t mode = oag_pkg::OAG_INH;
  logic [15:0] instr_pc = 16'h0100, operand_addr, pc_next;
  logic [7:0] index_reg = 8'hff, op_byte1, op_byte2, imm_data;
  logic [1:0] instr_len;
  logic res_valid, addr_valid, imm_valid, branch_taken;
  int errors = 0, total_checks = 0;
  oag_top u_oag_top (
    .clk(clk),
    .sys_rst(sys_rst),
    .instr_valid(instr_valid),
    .mode(mode),
    .branch_cond(branch_cond),
    .instr_pc(instr_pc),
    .index_reg(index_reg),
    .op_byte1(op_byte1),
    .op_byte2(op_byte2),
    .res_valid(res_valid),
    .instr_len(instr_len),
    .addr_valid(addr_valid),
    .operand_addr(operand_addr),
    .imm_valid(imm_valid),
    .imm_data(imm_data),
    .pc_next(pc_next),
    .branch_taken(branch_taken)
  );
  oag_mem_model u_oag_mem_model (.pc(instr_pc), .b1(op_byte1), .b2(op_byte2));
  initial forever #5 clk = ~clk;
  task chk(logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task go(oag_pkg::oag_mode_t m, logic c);
    @(posedge clk);
    instr_valid <= 1'h1;
    mode <= m;
    branch_cond <= c;
    @(posedge clk);
    instr_valid <= 1'h0;
    #1;
    chk(16'(res_valid), 16'h1);
  endtask : go
  task t_lens;
    logic [1:0] lens [9];
    lens = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3};
    for (int i = 0; i < 9; i++) begin
      go(oag_pkg::oag_mode_t'(i), 1'h1);
      chk(16'(instr_len), 16'(lens[i]));
    end
    $display("lens done");
  endtask : t_lens
  task t_addr;
    go(oag_pkg::OAG_INH, 1'h0);
    chk({14'h0000, addr_valid, imm_valid}, 16'h0000);
    go(oag_pkg::OAG_IMM, 1'h0);
    chk({7'h00, addr_valid, imm_data}, 16'h00ff);
    chk(16'(imm_valid), 16'h0001);
    go(oag_pkg::OAG_DIR, 1'h0);
    chk(operand_addr, 16'h00ff);
    chk(16'(addr_valid), 16'h0001);
    go(oag_pkg::OAG_EXT, 1'h0);
    chk(operand_addr, 16'hfffe);
    go(oag_pkg::OAG_IX2, 1'h0);
    chk(operand_addr, 16'h00fd);
    go(oag_pkg::OAG_IX1, 1'h0);
    chk(operand_addr, 16'h01fe);
    go(oag_pkg::OAG_IX0, 1'h0);
    chk(operand_addr, 16'h00ff);
    go(oag_pkg::OAG_BTB, 1'h0);
    chk(operand_addr, 16'h00ff);
    $display("addr done");
  endtask : t_addr
  task t_branch;
    go(oag_pkg::OAG_REL, 1'h1);
    chk(pc_next, 16'h0101);
    chk(16'(branch_taken), 16'h0001);
    go(oag_pkg::OAG_REL, 1'h0);
    chk(pc_next, 16'h0102);
    chk(16'(branch_taken), 16'h0000);
    go(oag_pkg::OAG_BTB, 1'h1);
    chk(pc_next, 16'h0101);
    chk(16'(branch_taken), 16'h0001);
    go(oag_pkg::OAG_BTB, 1'h0);
    chk(pc_next, 16'h0103);
    go(oag_pkg::OAG_EXT, 1'h1);
    chk(16'(branch_taken), 16'h0000);
    @(posedge clk);
    #1;
    chk({res_valid, 13'h0000, instr_len}, 16'h0003);
    $display("branch done");
  endtask : t_branch
  task test_done;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_lens;
    t_addr;
    t_branch;
    test_done;
  end
  initial begin
    repeat (500) @(posedge clk);
    errors++;
    test_done;
  end
endmodule : oag_top_tb
